// ---- hbd_decoder.sv ----
`timescale 1ns/1ps
module hbd_decoder #(
   parameter logic [7:0] TVVL_TICK_CYC = hbd_pkg::TVVL_TICK_CYC
) (
   input  wire logic          sys_clk_i,
   input  wire logic          rst_i,
   input  wire logic          drive_input_a_i,
   input  wire logic          drive_input_b_i,
   input  wire logic [1:0]    gate_current_feedback_i,
   input  wire logic [1:0]    output_on_feedback_i,
   input  wire logic          current_limit_active_i,
   input  hbd_pkg::hbd_cfg_t  cfg_i,
   input  wire logic          cfg_reset_i,
   input  wire logic          trig_sel_wr_i,
   input  wire logic          trig_sel_wdata_i,
   output hbd_pkg::hbd_gates_t gates_o,
   output logic               deadtime_trigger_sel_echo_o,
   output logic               direct_half_bridge_latched_o
);

   logic [5:0]          meta_r;
   logic [5:0]          sync_r;
   logic                in_a_s, in_b_s;
   logic [1:0]          gfb_s, ofb_s;
   logic                trig_r,  trig_nxt;
   logic                dlat_r,  dlat_nxt;
   logic [7:0]          pre_r,   pre_nxt;
   logic [17:0]         vt_r,    vt_nxt;
   logic                elapsed;
   hbd_pkg::hbd_req_t   req [2];
   logic [1:0]          hi_g, lo_g;

   ////////////////////////////////////////////////////////////////////////////
   // pins and gate/output feedback cross in through two flops; current_limit_active_i is used directly
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= 6'h00;
         sync_r <= 6'h00;
      end else begin
         meta_r <= {output_on_feedback_i, gate_current_feedback_i,
                    drive_input_b_i, drive_input_a_i};
         sync_r <= meta_r;
      end
   end

   assign in_a_s = sync_r[0];
   assign in_b_s = sync_r[1];
   assign gfb_s  = sync_r[3:2];
   assign ofb_s  = sync_r[5:4];

   ////////////////////////////////////////////////////////////////////////////
   // trigger select, mode latch and valve timer
   always_comb begin
      trig_nxt = trig_r;
      if (cfg_reset_i) trig_nxt = hbd_pkg::TRIG_SEL_RST;
      else if (trig_sel_wr_i) trig_nxt = trig_sel_wdata_i;
   end

   // latching only at idle avoids a mode swap in mid-drive
   always_comb begin
      dlat_nxt = dlat_r;
      if (!in_a_s && !in_b_s) dlat_nxt = cfg_i.direct_half_bridge_sel;
   end

   assign elapsed = (vt_r >= hbd_pkg::hbd_tvvl_ticks(cfg_i.valve_tristate_delay));

   // timer runs only while pulse is low in valve-hold; pulse high restarts it
   always_comb begin
      pre_nxt = 8'h00;
      vt_nxt  = 18'h00000;
      if (!dlat_r && cfg_i.valve_hold_mode && !in_a_s) begin
         pre_nxt = pre_r;
         vt_nxt  = vt_r;
         if (!elapsed) begin
            if (pre_r >= TVVL_TICK_CYC - 8'h01) begin
               pre_nxt = 8'h00;
               vt_nxt  = vt_r + 18'h00001;
            end else begin
               pre_nxt = pre_r + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_r <= hbd_pkg::TRIG_SEL_RST;
         dlat_r <= 1'b0;
         pre_r  <= 8'h00;
         vt_r   <= 18'h00000;
      end else begin
         trig_r <= trig_nxt;
         dlat_r <= dlat_nxt;
         pre_r  <= pre_nxt;
         vt_r   <= vt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input decode; input a is pulse, input b is rotation sense, unless direct mode is latched, where a drives half A and b drives half B
   always_comb begin
      req[0] = hbd_pkg::HBD_REQ_LO;
      req[1] = hbd_pkg::HBD_REQ_LO;
      if (dlat_r) begin
         req[0] = in_a_s ? hbd_pkg::HBD_REQ_HI : hbd_pkg::HBD_REQ_LO;
         req[1] = in_b_s ? hbd_pkg::HBD_REQ_HI : hbd_pkg::HBD_REQ_LO;
         if (in_a_s && in_b_s && current_limit_active_i) begin
            req[0] = hbd_pkg::HBD_REQ_LO;
            req[1] = hbd_pkg::HBD_REQ_LO;
         end
      end else if (in_a_s) begin
         req[0] = in_b_s ? hbd_pkg::HBD_REQ_HI : hbd_pkg::HBD_REQ_LO;
         req[1] = in_b_s ? hbd_pkg::HBD_REQ_LO : hbd_pkg::HBD_REQ_HI;
      end else if (cfg_i.valve_hold_mode && elapsed && !current_limit_active_i) begin
         req[0] = hbd_pkg::HBD_REQ_OFF;
         req[1] = hbd_pkg::HBD_REQ_OFF;
      end
      // otherwise both stay on low-side freewheeling
   end

   ////////////////////////////////////////////////////////////////////////////
   // one dead-time sequencer per half-bridge
   generate
      for (genvar h = 0; h < 2; h++) begin : g_half
         hbd_half_seq u_seq (
            .sys_clk_i               (sys_clk_i),
            .rst_i                   (rst_i),
            .req_i                   (req[h]),
            .gate_current_feedback_i (gfb_s[h]),
            .output_on_feedback_i    (ofb_s[h]),
            .trig_sel_i              (trig_r),
            .high_gate_o             (hi_g[h]),
            .low_gate_o              (lo_g[h])
         );
      end
   endgenerate

   // gate outputs already come from flops inside the sequencers
   assign gates_o.half_a_high_gate    = hi_g[0];
   assign gates_o.half_a_low_gate     = lo_g[0];
   assign gates_o.half_b_high_gate    = hi_g[1];
   assign gates_o.half_b_low_gate     = lo_g[1];
   assign deadtime_trigger_sel_echo_o = trig_r;
   assign direct_half_bridge_latched_o = dlat_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_fwd_decode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!dlat_r && in_a_s && in_b_s)
      |-> (req[0] == hbd_pkg::HBD_REQ_HI && req[1] == hbd_pkg::HBD_REQ_LO))
      else $error("forward decode wrong");

   a_rev_decode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!dlat_r && in_a_s && !in_b_s)
      |-> (req[0] == hbd_pkg::HBD_REQ_LO && req[1] == hbd_pkg::HBD_REQ_HI))
      else $error("reverse decode wrong");

   a_free_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!dlat_r && !in_a_s && !cfg_i.valve_hold_mode)
      |-> (req[0] == hbd_pkg::HBD_REQ_LO && req[1] == hbd_pkg::HBD_REQ_LO))
      else $error("default freewheel not on low sides");

   a_ilim_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (dlat_r && current_limit_active_i)
      |-> (req[0] != hbd_pkg::HBD_REQ_HI || req[1] != hbd_pkg::HBD_REQ_HI))
      else $error("high-side freewheel under current limit");

   a_tri_state: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!dlat_r && !in_a_s && cfg_i.valve_hold_mode && current_limit_active_i)
      |-> (req[0] == hbd_pkg::HBD_REQ_LO && req[1] == hbd_pkg::HBD_REQ_LO))
      else $error("tri-state during current limit");

   a_mode_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (dlat_r != $past(dlat_r)) |-> ($past(!in_a_s) && $past(!in_b_s)))
      else $error("mode latched while an input was high");

   a_trig_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $past(cfg_reset_i) |-> trig_r) else $error("trigger select not reloaded");

   a_timer_clr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      in_a_s |=> (vt_r == 18'h00000)) else $error("valve timer not restarted");

   a_trig_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (trig_sel_wr_i && !cfg_reset_i) |=> (trig_r == $past(trig_sel_wdata_i)))
      else $error("trigger select write lost");

   a_direct_fwd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (dlat_r && in_a_s && !in_b_s)
      |-> (req[0] == hbd_pkg::HBD_REQ_HI && req[1] == hbd_pkg::HBD_REQ_LO))
      else $error("direct forward decode wrong");

   a_direct_hs: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (dlat_r && in_a_s && in_b_s && !current_limit_active_i)
      |-> (req[0] == hbd_pkg::HBD_REQ_HI && req[1] == hbd_pkg::HBD_REQ_HI))
      else $error("direct high-side freewheel decode wrong");

   a_vh_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!dlat_r && cfg_i.valve_hold_mode && !in_a_s && !elapsed)
      |-> (req[0] == hbd_pkg::HBD_REQ_LO && req[1] == hbd_pkg::HBD_REQ_LO))
      else $error("valve hold left low sides early");

   a_vh_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!dlat_r && cfg_i.valve_hold_mode && !in_a_s && elapsed && !current_limit_active_i)
      |-> (req[0] == hbd_pkg::HBD_REQ_OFF && req[1] == hbd_pkg::HBD_REQ_OFF))
      else $error("bridge not tri-stated after delay");

endmodule : hbd_decoder

// ---- hbd_pkg.sv ----
package hbd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int          CLK_PERIOD_NS  = 25;
   localparam int          TSW_MIN_NS     = 1800;
   // least dead time, rounded up to whole cycles
   localparam logic [6:0]  TSW_MIN_CYC    = 7'((TSW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int          TVVL_TICK_NS   = 100;
   localparam logic [7:0]  TVVL_TICK_CYC  = 8'(TVVL_TICK_NS / CLK_PERIOD_NS);

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic        TRIG_SEL_RST   = 1'b1;
   localparam logic [3:0]  TVVL_CODE_RST  = 4'hF;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      HBD_REQ_OFF = 2'b00,
      HBD_REQ_HI  = 2'b01,
      HBD_REQ_LO  = 2'b10
   } hbd_req_t;

   typedef enum logic [1:0] {
      HBD_HS_OFF  = 2'b00,
      HBD_HS_HI   = 2'b01,
      HBD_HS_LO   = 2'b10,
      HBD_HS_DEAD = 2'b11
   } hbd_half_st_t;

   typedef struct packed {
      logic half_a_high_gate;
      logic half_a_low_gate;
      logic half_b_high_gate;
      logic half_b_low_gate;
   } hbd_gates_t;

   typedef struct packed {
      logic       valve_hold_mode;
      logic       direct_half_bridge_sel;
      logic [3:0] valve_tristate_delay;
   } hbd_cfg_t;

   // tri-state delay in 100 ns ticks; unused code 1110 takes the longest value
   function automatic logic [17:0] hbd_tvvl_ticks(input logic [3:0] code);
      logic [17:0] t;
      t = 18'h3F7A0;
      case (code)
         4'h0:    t = 18'h00000;
         4'h1:    t = 18'h00040;
         4'h2:    t = 18'h0007E;
         4'h3:    t = 18'h000F8;
         4'h4:    t = 18'h001F8;
         4'h5:    t = 18'h003E8;
         4'h6:    t = 18'h007D0;
         4'h7:    t = 18'h00FA0;
         4'h8:    t = 18'h01F40;
         4'h9:    t = 18'h03E80;
         4'hA:    t = 18'h07D00;
         4'hB:    t = 18'h0FDE8;
         4'hC:    t = 18'h1FBD0;
         default: t = 18'h3F7A0;
      endcase
      return t;
   endfunction : hbd_tvvl_ticks

endpackage : hbd_pkg

// ---- hbd_half_seq.sv ----
`timescale 1ns/1ps
module hbd_half_seq (
   input  wire logic            sys_clk_i,
   input  wire logic            rst_i,
   input  hbd_pkg::hbd_req_t    req_i,
   input  wire logic            gate_current_feedback_i,
   input  wire logic            output_on_feedback_i,
   input  wire logic            trig_sel_i,
   output logic                 high_gate_o,
   output logic                 low_gate_o
);

   hbd_pkg::hbd_half_st_t state_r,  state_nxt;
   logic [6:0]            cnt_r,    cnt_nxt;
   logic                  gfb_r,    gfb_nxt;
   logic                  ofb_r,    ofb_nxt;
   logic                  hi_r,     lo_r;
   logic                  done;

   ////////////////////////////////////////////////////////////////////////////
   // dead interval ends on feedback, never on the count alone
   always_comb begin
      done = (cnt_r >= hbd_pkg::TSW_MIN_CYC - 7'h01)
             && (gfb_r || gate_current_feedback_i)
             && (!trig_sel_i || ofb_r || output_on_feedback_i);
   end

   // a slow slew setting simply delays the feedback and stretches the dead time
   always_comb begin
      state_nxt  = state_r;
      cnt_nxt    = cnt_r;
      gfb_nxt    = gfb_r;
      ofb_nxt    = ofb_r;
      case (state_r)
         hbd_pkg::HBD_HS_OFF: begin
            // the partner may have just turned off, so every turn-on waits out a dead interval
            if (req_i != hbd_pkg::HBD_REQ_OFF) begin
               state_nxt  = hbd_pkg::HBD_HS_DEAD;
               cnt_nxt    = 7'h00;
               gfb_nxt    = 1'b0;
               ofb_nxt    = 1'b0;
            end
         end
         hbd_pkg::HBD_HS_HI, hbd_pkg::HBD_HS_LO: begin
            if (req_i == hbd_pkg::HBD_REQ_OFF) begin
               state_nxt = hbd_pkg::HBD_HS_OFF;
            end else if ((req_i == hbd_pkg::HBD_REQ_HI) != (state_r == hbd_pkg::HBD_HS_HI)) begin
               state_nxt  = hbd_pkg::HBD_HS_DEAD;
               cnt_nxt    = 7'h00;
               gfb_nxt    = 1'b0;
               ofb_nxt    = 1'b0;
            end
         end
         hbd_pkg::HBD_HS_DEAD: begin
            if (cnt_r != 7'h7F) cnt_nxt = cnt_r + 7'h01;
            gfb_nxt = gfb_r | gate_current_feedback_i;
            ofb_nxt = ofb_r | output_on_feedback_i;
            if (req_i == hbd_pkg::HBD_REQ_OFF) begin
               state_nxt = hbd_pkg::HBD_HS_OFF;
            end else begin
               if (done) begin
                  state_nxt = (req_i == hbd_pkg::HBD_REQ_HI) ? hbd_pkg::HBD_HS_HI
                                                             : hbd_pkg::HBD_HS_LO;
               end
            end
         end
         default: state_nxt = hbd_pkg::HBD_HS_OFF;
      endcase
   end

   // gates follow the next state so they match state_r cycle for cycle
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r  <= hbd_pkg::HBD_HS_OFF;
         cnt_r    <= 7'h00;
         gfb_r    <= 1'b0;
         ofb_r    <= 1'b0;
         hi_r     <= 1'b0;
         lo_r     <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         cnt_r    <= cnt_nxt;
         gfb_r    <= gfb_nxt;
         ofb_r    <= ofb_nxt;
         hi_r     <= (state_nxt == hbd_pkg::HBD_HS_HI);
         lo_r     <= (state_nxt == hbd_pkg::HBD_HS_LO);
      end
   end

   assign high_gate_o = hi_r;
   assign low_gate_o  = lo_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_dead_exit;
      (state_r == hbd_pkg::HBD_HS_DEAD) ##1
      (state_r == hbd_pkg::HBD_HS_HI || state_r == hbd_pkg::HBD_HS_LO);
   endsequence

   a_no_shoot: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !(hi_r && lo_r)) else $error("both gates of one half-bridge on");

   a_dead_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_r == hbd_pkg::HBD_HS_DEAD) |-> (!hi_r && !lo_r))
      else $error("gate on during dead interval");

   a_dead_min: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_dead_exit |-> ($past(cnt_r) >= hbd_pkg::TSW_MIN_CYC - 7'h01))
      else $error("dead interval shorter than minimum");

   a_dead_fb: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_dead_exit |-> ($past(gfb_r || gate_current_feedback_i)
                      && ($past(!trig_sel_i) || $past(ofb_r || output_on_feedback_i))))
      else $error("dead interval ended without feedback");

   a_hi_to_lo: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (hi_r && req_i == hbd_pkg::HBD_REQ_LO) |=> (!hi_r && !lo_r))
      else $error("direct switch without dead interval");

   a_off_dead: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_r == hbd_pkg::HBD_HS_OFF && req_i != hbd_pkg::HBD_REQ_OFF)
      |=> (state_r == hbd_pkg::HBD_HS_DEAD))
      else $error("turn-on from off without dead interval");

endmodule : hbd_half_seq

// ---- hbd_mcu_model.sv ----
`timescale 1ns/1ps
module hbd_mcu_model #(
   parameter int HOLD_CYC = 40
) (
   input  wire logic sys_clk_i,
   input  wire logic go_i,
   input  wire logic a_i,
   input  wire logic b_i,
   input  wire logic direct_i,
   input  wire logic allow_hs_i,
   output logic      drive_input_a_o,
   output logic      drive_input_b_o,
   output logic      busy_o
);
   int   hold_r = 0;
   // pins rest low, as the pad pull-downs would leave them
   logic a_r    = 1'b0;
   logic b_r    = 1'b0;

   assign drive_input_a_o = a_r;
   assign drive_input_b_o = b_r;
   assign busy_o          = (hold_r != 0);

   // a new level is taken only once the last one has been held long enough
   always @(posedge sys_clk_i) begin
      if (hold_r != 0) begin
         hold_r <= hold_r - 1;
      end else if (go_i) begin
         a_r             <= a_i;
         // high-side freewheel in direct mode only when explicitly allowed
         b_r             <= b_i & ~(direct_i & a_i & ~allow_hs_i);
         hold_r          <= HOLD_CYC;
      end
   end
endmodule : hbd_mcu_model

// ---- hbd_decoder_tb.sv ----
`timescale 1ns/1ps
module hbd_decoder_tb;
   logic                sys_clk;
   logic                rst;
   logic                go;
   logic                cmd_a;
   logic                cmd_b;
   logic                allow;
   logic                busy;
   logic                pin_a;
   logic                pin_b;
   logic [1:0]          gcf;
   logic [1:0]          oof;
   logic                cl;
   hbd_pkg::hbd_cfg_t   cfg;
   logic                crst;
   logic                tw;
   logic                twd;
   hbd_pkg::hbd_gates_t gates;
   logic                echo;
   logic                latched;
   int                  fail_count = 0;
   int                  n_compared = 0;
   int                  cyc        = 0;
   int                  dcnt [2];
   logic [1:0]          last [2];

   ////////////////////////////////////////////////////////////////////////////
   hbd_mcu_model u_mcu (
      .sys_clk_i(sys_clk), .go_i(go), .a_i(cmd_a), .b_i(cmd_b),
      .direct_i(cfg.direct_half_bridge_sel), .allow_hs_i(allow),
      .drive_input_a_o(pin_a), .drive_input_b_o(pin_b), .busy_o(busy)
   );

   // one-cycle ticks shorten the tri-state delay in simulation
   hbd_decoder #(.TVVL_TICK_CYC(8'h01)) u_dut (
      .sys_clk_i(sys_clk), .rst_i(rst), .drive_input_a_i(pin_a),
      .drive_input_b_i(pin_b), .gate_current_feedback_i(gcf),
      .output_on_feedback_i(oof), .current_limit_active_i(cl), .cfg_i(cfg),
      .cfg_reset_i(crst), .trig_sel_wr_i(tw), .trig_sel_wdata_i(twd),
      .gates_o(gates), .deadtime_trigger_sel_echo_o(echo),
      .direct_half_bridge_latched_o(latched)
   );

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic end_of_test;
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   // gate pattern {a_hi, a_lo, b_hi, b_lo} for settled inputs
   function automatic logic [3:0] dec(input logic a, b, direct, lim);
      if (direct) return (a & b & lim) ? 4'h5 : {a, ~a, b, ~b};
      if (!a) return 4'h5;
      return b ? 4'h9 : 4'h6;
   endfunction : dec

   task automatic drive(input logic a, input logic b);
      @(posedge sys_clk);
      cmd_a <= a;
      cmd_b <= b;
      go    <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      @(negedge sys_clk);
      while (busy) @(negedge sys_clk);
   endtask : drive

   // polls under a bound, since the dead interval depends on feedback
   task automatic expect_gates(input logic [3:0] exp);
      int n;
      n = 0;
      while (gates !== exp && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      chk("gates", 8'(gates), 8'(exp));
   endtask : expect_gates

   task automatic trig(input logic wr, input logic d, input logic rs);
      @(posedge sys_clk);
      tw   <= wr;
      twd  <= d;
      crst <= rs;
      @(posedge sys_clk);
      tw   <= 1'b0;
      crst <= 1'b0;
      @(negedge sys_clk);
   endtask : trig

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wait_cyc

   ////////////////////////////////////////////////////////////////////////////
   // watches every half for overlap and for a short dead interval
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         end_of_test();
      end
      for (int h = 0; h < 2; h++) begin
         logic hi;
         logic lo;
         hi = gates[3-2*h];
         lo = gates[2-2*h];
         if (hi & lo) chk("overlap", 8'h01, 8'h00);
         if (rst) last[h] = 2'h0;
         if (!hi && !lo) begin
            dcnt[h]++;
         end else begin
            if ((hi && last[h] == 2'h2) || (lo && last[h] == 2'h1))
               chk("dead", 8'(dcnt[h] >= int'(hbd_pkg::TSW_MIN_CYC)), 8'h01);
            last[h] = hi ? 2'h1 : 2'h2;
            dcnt[h] = 0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [1:0] ab;
      logic       lim;
      rst = 1'b1; go = 1'b0; cmd_a = 1'b0; cmd_b = 1'b0; allow = 1'b0;
      gcf = 2'h3; oof = 2'h3; cl = 1'b0; crst = 1'b0; tw = 1'b0; twd = 1'b0;
      cfg = '{1'b0, 1'b0, 4'hF};
      dcnt = '{0, 0};
      last = '{2'h0, 2'h0};
      void'($urandom(32'hF8741565));
      repeat (16) @(posedge sys_clk);
      chk("rst_gates", 8'(gates), 8'h00);
      chk("rst_echo", 8'(echo), 8'h01);
      chk("rst_latch", 8'(latched), 8'h00);
      rst <= 1'b0;
      // trigger select write, reload and echo
      trig(1'b1, 1'b0, 1'b0);
      chk("echo", 8'(echo), 8'h00);
      trig(1'b0, 1'b0, 1'b1);
      chk("echo", 8'(echo), 8'h01);
      trig(1'b1, 1'b0, 1'b1);
      chk("echo", 8'(echo), 8'h01);
      trig(1'b1, 1'b0, 1'b0);
      chk("echo", 8'(echo), 8'h00);
      // default interpretation, full table then random
      for (int i = 0; i < 14; i++) begin
         ab = (i < 4) ? 2'(i) : 2'($urandom);
         drive(ab[1], ab[0]);
         expect_gates(dec(ab[1], ab[0], 1'b0, 1'b0));
      end
      // dead interval held until the selected feedback arrives
      drive(1'b0, 1'b0);
      expect_gates(4'h5);
      @(posedge sys_clk);
      gcf <= 2'h0;
      oof <= 2'h0;
      drive(1'b1, 1'b1);
      wait_cyc(110);
      chk("dead_wait", 8'(gates), 8'h01);
      @(posedge sys_clk);
      gcf <= 2'h3;
      expect_gates(4'h9);
      drive(1'b0, 1'b0);
      expect_gates(4'h5);
      trig(1'b1, 1'b1, 1'b0);
      drive(1'b1, 1'b1);
      wait_cyc(110);
      chk("dead_late", 8'(gates), 8'h01);
      @(posedge sys_clk);
      oof <= 2'h3;
      expect_gates(4'h9);
      // direct select refused while an input is high, then latched
      drive(1'b1, 1'b0);
      @(posedge sys_clk);
      cfg.direct_half_bridge_sel <= 1'b1;
      wait_cyc(10);
      chk("latch_hold", 8'(latched), 8'h00);
      drive(1'b0, 1'b0);
      chk("latch_set", 8'(latched), 8'h01);
      allow <= 1'b1;
      for (int i = 0; i < 14; i++) begin
         ab  = (i < 4) ? 2'(i) : ((i == 4) ? 2'h3 : 2'($urandom));
         lim = (i == 4) ? 1'b1 : ((i < 4) ? 1'b0 : 1'($urandom));
         @(posedge sys_clk);
         cl  <= lim;
         drive(ab[1], ab[0]);
         expect_gates(dec(ab[1], ab[0], 1'b1, lim));
      end
      @(posedge sys_clk);
      cl    <= 1'b0;
      allow <= 1'b0;
      drive(1'b0, 1'b0);
      @(posedge sys_clk);
      cfg <= '{1'b0, 1'b0, 4'h2};
      wait_cyc(10);
      chk("latch_clr", 8'(latched), 8'h00);
      // valve hold: low sides, then tri-state, unless current limit
      @(posedge sys_clk);
      cfg.valve_hold_mode <= 1'b1;
      drive(1'b1, 1'b1);
      expect_gates(4'h9);
      drive(1'b0, 1'b0);
      expect_gates(4'h5);
      expect_gates(4'h0);
      @(posedge sys_clk);
      cl <= 1'b1;
      drive(1'b1, 1'b1);
      expect_gates(4'h9);
      drive(1'b0, 1'b0);
      expect_gates(4'h5);
      wait_cyc(300);
      chk("vh_limit", 8'(gates), 8'h05);
      @(posedge sys_clk);
      cl <= 1'b0;
      cfg.valve_tristate_delay <= 4'h0;
      drive(1'b1, 1'b1);
      expect_gates(4'h9);
      drive(1'b0, 1'b0);
      expect_gates(4'h0);
      trig(1'b1, 1'b0, 1'b0);
      chk("echo", 8'(echo), 8'h00);
      // reset in mid-run reloads everything
      @(posedge sys_clk);
      rst <= 1'b1;
      @(negedge sys_clk);
      chk("rst2_gates", 8'(gates), 8'h00);
      chk("rst2_echo", 8'(echo), 8'h01);
      @(posedge sys_clk);
      rst <= 1'b0;
      drive(1'b1, 1'b1);
      chk("rst2_latch", 8'(latched), 8'h00);
      expect_gates(4'h9);
      end_of_test();
   end
endmodule : hbd_decoder_tb
